// ### aes3_status_pkg.sv
// Purpose: Shared constants and types for the four-link serial audio output with channel status.
// Assumes: One 250 MHz clock; frame and half-cell timing arrive as one-cycle enable pulses.
// Notes:   Channel status follows the professional layout; bit 0 of each byte is sent first.
//
// Operation
// - Rate field in channel status follows current sample rate, 32 to 192 kHz.
// - Status marks audio use, no copy protection, copying allowed.
// - Category general and generation not indicated are carried in status.
// - Status signals professional format, two-channel mode and no pre-emphasis.
// - Auxiliary bits declared as audio, giving 24-bit sample words.
// - Each link runs single-wire only, frame rate 32 to 192 kHz.
// - Eight channels leave on four links, one channel pair per link.
// - Each link's audio sample rate equals its own frame rate.
// - Analog source by default; optical, USB, MADI or serial inputs selectable.
// - Four serial inputs serve as audio sources and as clock reference.
package aes3_status_pkg;

   // ==========================================================================
   // Sizes
   localparam int SMP_W        = 24;
   localparam int NCH          = 8;
   localparam int NLINK        = 4;
   localparam int UI_CNT_W     = 7;
   localparam int CS_IDX_W     = 8;
   localparam logic [6:0] UI_LAST     = 7'h7F;
   localparam logic [6:0] UI_SUB_LAST = 7'h3F;
   localparam logic [4:0] PRE_SLOTS   = 5'h04;
   localparam logic [7:0] CS_LAST     = 8'hBF;
   localparam logic [7:0] CS_CRC_IDX  = 8'hB8;

   // ==========================================================================
   // Subframe word layout
   localparam int W_AUD_LSB = 4;
   localparam int W_V       = 28;
   localparam int W_U       = 29;
   localparam int W_C       = 30;
   localparam int W_P       = 31;

   // ==========================================================================
   // Preamble half-cell patterns, for a preceding line level of zero
   localparam logic [7:0] PAT_Z = 8'hE8;
   localparam logic [7:0] PAT_X = 8'hE2;
   localparam logic [7:0] PAT_Y = 8'hE4;

   // ==========================================================================
   // Channel status field values
   localparam logic [7:0] CS_B0_PRO      = 8'h01;
   localparam logic [7:0] CS_B0_NO_EMPH  = 8'h04;
   localparam logic [7:0] CS_B0_FS_32K   = 8'hC0;
   localparam logic [7:0] CS_B0_FS_44K1  = 8'h80;
   localparam logic [7:0] CS_B0_FS_48K   = 8'h40;
   localparam logic [7:0] CS_B1_TWO_CH   = 8'h01;
   localparam logic [7:0] CS_B2_AUX_AUD  = 8'h01;
   localparam logic [7:0] CS_B2_WLEN_24  = 8'h28;
   localparam logic [7:0] CS_B4_64K      = 8'h08;
   localparam logic [7:0] CS_B4_88K2     = 8'h50;
   localparam logic [7:0] CS_B4_96K      = 8'h10;
   localparam logic [7:0] CS_B4_176K4    = 8'h58;
   localparam logic [7:0] CS_B4_192K     = 8'h18;
   localparam logic [4:0] CS_BYTE_ORG0   = 5'h06;
   localparam logic [4:0] CS_BYTE_ORG3   = 5'h09;
   localparam logic [7:0] CRC_POLY       = 8'h1D;
   localparam logic [7:0] CRC_INIT       = 8'hFF;

   // ==========================================================================
   // Modes
   typedef enum logic [2:0] {RATE_32K, RATE_44K1, RATE_48K, RATE_64K,
                             RATE_88K2, RATE_96K, RATE_176K4, RATE_192K} rate_t;
   typedef enum logic [2:0] {SRC_ANALOG, SRC_OPTICAL, SRC_USB, SRC_MADI,
                             SRC_AES} src_t;
   typedef enum logic [2:0] {REF_INTERNAL, REF_AES1, REF_AES2, REF_AES3,
                             REF_AES4} ref_t;
   typedef enum logic [1:0] {PRE_X, PRE_Y, PRE_Z} pre_t;

endpackage

// ### link_if.sv
`timescale 1ns/1ps
// Purpose: Shared half-cell timing from the frame sequencer to the link encoders.
// Assumes: Driven by the top module only.
// Notes:   All signals are valid in the cycle where ui_en is high.
interface link_if;
   import aes3_status_pkg::*;
   logic       ui_en;
   logic [4:0] slot;
   logic       half;
   pre_t       pre;
   modport ctl (output ui_en, output slot, output half, output pre);
   modport enc (input ui_en, input slot, input half, input pre);
endinterface

// ### cs_status_gen.sv
`timescale 1ns/1ps
// Purpose: Channel status block source, one bit per frame with trailing CRC byte.
// Assumes: adv pulses once per frame, before the frame's first subframe word is built.
// Notes:   The rate is captured at block start so a block never mixes two rate codes.
module cs_status_gen
   import aes3_status_pkg::*;
#(
   parameter logic [31:0] ORIGIN = 32'h4745_4E30 // Arbitrary neutral origin text.
) (
   input  wire logic  clk,
   input  wire logic  rstn,
   input  wire logic  adv,
   input  wire rate_t rate,
   output logic       cs_q,
   output logic       first_q
);
   logic [CS_IDX_W-1:0] idx_q, idx_d;
   logic [7:0]          crc_q, crc_d;
   rate_t               rate_q, rate_d;
   logic                cs_d, first_d;
   rate_t               eff_rate;
   logic [7:0]          byte_v;
   logic                bit_v;
   logic [7:0]          crc_base;

   // ==========================================================================
   // Status byte table
   function automatic logic [7:0] cs_byte(input logic [4:0] n, input rate_t r);
      logic [7:0] b;
      b = 8'h00;
      case (n)
         5'h00: begin
            b = CS_B0_PRO | CS_B0_NO_EMPH;
            case (r)
               RATE_32K:  b = b | CS_B0_FS_32K;
               RATE_44K1: b = b | CS_B0_FS_44K1;
               RATE_48K:  b = b | CS_B0_FS_48K;
               default:   b = b;
            endcase
         end
         5'h01: b = CS_B1_TWO_CH;
         5'h02: b = CS_B2_AUX_AUD | CS_B2_WLEN_24;
         5'h04: begin
            case (r)
               RATE_64K:   b = CS_B4_64K;
               RATE_88K2:  b = CS_B4_88K2;
               RATE_96K:   b = CS_B4_96K;
               RATE_176K4: b = CS_B4_176K4;
               RATE_192K:  b = CS_B4_192K;
               default:    b = 8'h00;
            endcase
         end
         default: begin
            if (n >= CS_BYTE_ORG0 && n <= CS_BYTE_ORG3) begin
               b = ORIGIN[8*(3-(n-CS_BYTE_ORG0)) +: 8];
            end
         end
      endcase
      // Category and generation fields stay zero: general, not indicated.
      return b;
   endfunction

   // ==========================================================================
   // Block sequencing and CRC
   always_comb begin
      eff_rate = (idx_q == '0) ? rate : rate_q;
      byte_v   = cs_byte(idx_q[7:3], eff_rate);
      bit_v    = (idx_q < CS_CRC_IDX) ? byte_v[idx_q[2:0]] : crc_q[idx_q[2:0]];
      crc_base = (idx_q == '0) ? CRC_INIT : crc_q;
      idx_d    = idx_q;
      crc_d    = crc_q;
      rate_d   = rate_q;
      cs_d     = cs_q;
      first_d  = first_q;
      if (adv) begin
         cs_d    = bit_v;
         first_d = (idx_q == '0);
         rate_d  = eff_rate;
         idx_d   = (idx_q == CS_LAST) ? '0 : idx_q + 8'h01;
         if (idx_q < CS_CRC_IDX) begin
            crc_d = {crc_base[6:0], 1'b0} ^ ((crc_base[7] ^ bit_v) ? CRC_POLY : 8'h00);
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         idx_q   <= '0;
         crc_q   <= CRC_INIT;
         rate_q  <= RATE_48K;
         cs_q    <= 1'b0;
         first_q <= 1'b0;
      end else begin
         idx_q   <= idx_d;
         crc_q   <= crc_d;
         rate_q  <= rate_d;
         cs_q    <= cs_d;
         first_q <= first_d;
      end
   end
endmodule

// ### bmc_encoder.sv
`timescale 1ns/1ps
// Purpose: Biphase-mark line encoder for one link, preambles included.
// Assumes: word stays stable for the whole subframe it belongs to.
// Notes:   Preamble polarity follows the level left by the previous subframe.
module bmc_encoder
   import aes3_status_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   link_if.enc              lnk,
   input  wire logic [31:0] word,
   output logic             line_q
);
   logic       line_d;
   logic       base_q, base_d;
   logic [7:0] pat;
   logic [2:0] pidx;
   logic       pre_start;

   always_comb begin
      case (lnk.pre)
         PRE_Z:   pat = PAT_Z;
         PRE_Y:   pat = PAT_Y;
         default: pat = PAT_X;
      endcase
      pidx      = ~{lnk.slot[1:0], lnk.half};
      pre_start = (lnk.slot == '0) && !lnk.half;
      line_d    = line_q;
      base_d    = base_q;
      if (lnk.ui_en) begin
         if (lnk.slot < PRE_SLOTS) begin
            if (pre_start) begin
               base_d = line_q;
            end
            line_d = pat[pidx] ^ (pre_start ? line_q : base_q);
         end else if (!lnk.half || word[lnk.slot]) begin
            line_d = ~line_q;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         line_q <= 1'b0;
         base_q <= 1'b0;
      end else begin
         line_q <= line_d;
         base_q <= base_d;
      end
   end
endmodule

// ### aes3_output_status_gen.sv
`timescale 1ns/1ps
// Purpose: Four-link single-wire serial audio output with professional channel status.
// Assumes: ui_tick pulses 128 times per frame, locked to the selected reference.
// Notes:   A reference tick always restarts the frame, so the frame rate is the reference rate.
module aes3_output_status_gen
   import aes3_status_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire logic                 ui_tick,
   input  wire logic                 int_frame_tick,
   input  wire logic [NLINK-1:0]     aes_in_frame_tick,
   input  wire ref_t                 ref_sel,
   input  wire src_t                 src_sel,
   input  wire rate_t                rate_sel,
   input  wire logic [NCH*SMP_W-1:0] src_analog,
   input  wire logic [NCH*SMP_W-1:0] src_optical,
   input  wire logic [NCH*SMP_W-1:0] src_usb,
   input  wire logic [NCH*SMP_W-1:0] src_madi,
   input  wire logic [NCH*SMP_W-1:0] src_aes,
   output logic [NLINK-1:0]          aes_out,
   output logic                      block_start_q,
   output rate_t                     frame_rate_q
);

   // ==========================================================================
   // Declarations
   link_if lnk ();

   logic [UI_CNT_W-1:0] cnt_q, cnt_d;
   logic                run_q, run_d;
   logic                ref_tick;
   logic [NCH*SMP_W-1:0] sel_smp;
   logic [31:0]         word_q [NLINK];
   logic [31:0]         word_d [NLINK];
   logic [SMP_W-1:0]    smp_b_q [NLINK];
   logic [SMP_W-1:0]    smp_b_d [NLINK];
   logic                block_start_d;
   rate_t               frame_rate_d;
   logic                step;
   logic                cs_adv;
   logic                cs_bit;
   logic                cs_first;

   // ==========================================================================
   // Word builder
   // Validity, user bit and preamble slots are zero; parity makes bits 4..31 even.
   function automatic logic [31:0] make_word(input logic [SMP_W-1:0] smp,
                                              input logic c);
      logic [31:0] w;
      w              = 32'h0000_0000;
      w[W_AUD_LSB +: SMP_W] = smp;
      w[W_V]         = 1'b0;
      w[W_U]         = 1'b0;
      w[W_C]         = c;
      w[W_P]         = ^w[W_C:W_AUD_LSB];
      return w;
   endfunction

   // ==========================================================================
   // Clock reference selection
   // A serial input only ever acts as a frame reference here; its lock state is
   // judged upstream, which must stop its tick when the input is lost.
   always_comb begin
      case (ref_sel)
         REF_AES1: ref_tick = aes_in_frame_tick[0];
         REF_AES2: ref_tick = aes_in_frame_tick[1];
         REF_AES3: ref_tick = aes_in_frame_tick[2];
         REF_AES4: ref_tick = aes_in_frame_tick[3];
         default:  ref_tick = int_frame_tick;
      endcase
   end

   // ==========================================================================
   // Source routing
   always_comb begin
      case (src_sel)
         SRC_OPTICAL: sel_smp = src_optical;
         SRC_USB:     sel_smp = src_usb;
         SRC_MADI:    sel_smp = src_madi;
         SRC_AES:     sel_smp = src_aes;
         default:     sel_smp = src_analog;
      endcase
   end

   // ==========================================================================
   // Frame sequencer
   // The counter walks the 128 half-cells of one frame and then stops. Without
   // a fresh reference tick the lines go quiet rather than free-run at a rate
   // that nobody asked for.
   assign step   = ui_tick && run_q;
   assign cs_adv = step && (cnt_q == UI_SUB_LAST);

   always_comb begin
      cnt_d = cnt_q;
      run_d = run_q;
      if (ref_tick) begin
         cnt_d = '0;
         run_d = 1'b1;
      end else if (step) begin
         if (cnt_q == UI_LAST) begin
            run_d = 1'b0;
         end else begin
            cnt_d = cnt_q + 7'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= run_d;
      end
   end

   // ==========================================================================
   // Shared half-cell timing towards the encoders
   always_comb begin
      lnk.ui_en = step;
      lnk.slot  = cnt_q[5:1];
      lnk.half  = cnt_q[0];
      if (cnt_q[6]) begin
         lnk.pre = PRE_Y;
      end else if (cs_first) begin
         lnk.pre = PRE_Z;
      end else begin
         lnk.pre = PRE_X;
      end
   end

   // ==========================================================================
   // Subframe words
   // Channel A words are built at the reference tick straight from the source,
   // and the matching channel B samples are caught in the same cycle so both
   // halves of a frame belong to one sample instant.
   always_comb begin
      for (int i = 0; i < NLINK; i++) begin
         word_d[i]  = word_q[i];
         smp_b_d[i] = smp_b_q[i];
         if (ref_tick) begin
            word_d[i]  = make_word(sel_smp[(2*i)*SMP_W +: SMP_W], cs_bit);
            smp_b_d[i] = sel_smp[(2*i+1)*SMP_W +: SMP_W];
         end else if (cs_adv) begin
            word_d[i] = make_word(smp_b_q[i], cs_bit);
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NLINK; i++) begin
            word_q[i]  <= 32'h0000_0000;
            smp_b_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NLINK; i++) begin
            word_q[i]  <= word_d[i];
            smp_b_q[i] <= smp_b_d[i];
         end
      end
   end

   // ==========================================================================
   // Status outputs
   always_comb begin
      block_start_d = step && (cnt_q == '0) && cs_first;
      frame_rate_d  = ref_tick ? rate_sel : frame_rate_q;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         block_start_q <= 1'b0;
         frame_rate_q  <= RATE_48K;
      end else begin
         block_start_q <= block_start_d;
         frame_rate_q  <= frame_rate_d;
      end
   end

   // ==========================================================================
   // Channel status source
   // Advanced mid-frame so the next frame's bit is ready before its words are
   // built; both channels of a link carry the same status bit.
   cs_status_gen u_cs (
      .clk     (clk),
      .rstn    (rstn),
      .adv     (cs_adv),
      .rate    (rate_sel),
      .cs_q    (cs_bit),
      .first_q (cs_first)
   );

   // ==========================================================================
   // Link encoders
   for (genvar g = 0; g < NLINK; g++) begin : g_link
      bmc_encoder u_enc (
         .clk    (clk),
         .rstn   (rstn),
         .lnk    (lnk),
         .word   (word_q[g]),
         .line_q (aes_out[g])
      );
   end

endmodule

// ### aes3_output_status_gen_chk.sv
// Purpose: Port checker for the four-link status output.
// Assumes: One clock; rstn low clears aes_out and block_start_q and sets frame_rate_q to RATE_48K.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/1ps
module aes3_output_status_gen_chk
   import aes3_status_pkg::*;
(
   input wire logic             clk,
   input wire logic             rstn,
   input wire logic             ui_tick,
   input wire logic             int_frame_tick,
   input wire logic [NLINK-1:0] aes_in_frame_tick,
   input wire ref_t             ref_sel,
   input wire rate_t            rate_sel,
   input wire logic [NLINK-1:0] aes_out,
   input wire logic             block_start_q,
   input wire rate_t            frame_rate_q
);
   logic live_q;

   // The sampled-value functions look back across a reset release, where the lines
   // were cleared without a half-cell tick, so the first edge after it is skipped.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         live_q <= 1'b0;
      end else begin
         live_q <= 1'b1;
      end
   end

   // ==========
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_int_capture: assert property (int_frame_tick && ref_sel == REF_INTERNAL
      |=> frame_rate_q == $past(rate_sel)) else $error("rate missed at internal tick");
   a_aes_capture: assert property (aes_in_frame_tick[1] && ref_sel == REF_AES2
      |=> frame_rate_q == $past(rate_sel)) else $error("rate missed at serial tick");
   a_int_ignored: assert property (!int_frame_tick && ref_sel == REF_INTERNAL
      |=> $stable(frame_rate_q)) else $error("rate moved without internal tick");
   a_aes_ignored: assert property (!aes_in_frame_tick[0] && ref_sel == REF_AES1
      |=> $stable(frame_rate_q)) else $error("rate moved without serial tick");
   a_line_hold: assert property (live_q && !$past(ui_tick) |-> $stable(aes_out))
      else $error("line moved without half-cell tick");
   a_start_single: assert property (block_start_q |=> !block_start_q [*8])
      else $error("block start longer than one pulse");
   a_start_tick: assert property (block_start_q |-> $past(ui_tick))
      else $error("block start off the half-cell tick");
   a_start_edge: assert property (block_start_q |-> aes_out == ~$past(aes_out))
      else $error("block start without line transition");
endmodule
bind aes3_output_status_gen aes3_output_status_gen_chk aes3_output_status_gen_chk_inst (
   .clk, .rstn, .ui_tick, .int_frame_tick, .aes_in_frame_tick, .ref_sel,
   .rate_sel, .aes_out, .block_start_q, .frame_rate_q);

// ### bmc_rx_model.sv
// Purpose: Receiver model that decodes one biphase-mark link.
// Assumes: stb marks each settled half-cell on line.
// Notes:   A preamble is found by matching eight half-cells against PAT_Z, PAT_X, PAT_Y or their inverses.
`timescale 1ns/1ps
module bmc_rx_model
   import aes3_status_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   rstn,
   input  wire logic   stb,
   input  wire logic   line,
   output logic        ok_q,
   output pre_t        kind_q,
   output logic [27:0] bits
);
   // ==========
   // Decoder
   logic [7:0]  sr_q;
   logic [55:0] dat_q;
   logic [5:0]  cnt_q;
   logic        run_q;
   logic [7:0]  w;
   assign w = {sr_q[6:0], line};
   // A cell is a one when its two halves differ.
   always_comb
      for (int i = 0; i < 28; i++)
         bits[i] = dat_q[55-2*i] ^ dat_q[54-2*i];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sr_q   <= 8'h00;
         dat_q  <= '0;
         cnt_q  <= 6'h00;
         run_q  <= 1'b0;
         ok_q   <= 1'b0;
         kind_q <= PRE_X;
      end else begin
         ok_q <= 1'b0;
         if (stb) begin
            sr_q <= w;
            if (w inside {PAT_Z, ~PAT_Z, PAT_X, ~PAT_X, PAT_Y, ~PAT_Y}) begin
               run_q  <= 1'b1;
               cnt_q  <= 6'h00;
               kind_q <= (w == PAT_Z || w == ~PAT_Z) ? PRE_Z :
                         (w == PAT_X || w == ~PAT_X) ? PRE_X : PRE_Y;
            end else if (run_q) begin
               dat_q <= {dat_q[54:0], line};
               cnt_q <= cnt_q + 6'h01;
               ok_q  <= (cnt_q == 6'h37);
               run_q <= (cnt_q != 6'h37);
            end
         end
      end
   end
endmodule

// ### aes3_output_status_gen_tb_top.sv
// Purpose: Self-checking bench for the four-link status output.
// Assumes: Half-cell ticks every other cycle, every cycle in the status block run.
// Notes:   Status blocks run on 64 half-cell frames to keep the run short.
`timescale 1ns/1ps
module aes3_output_status_gen_tb_top
   import aes3_status_pkg::*;
;
   // ==========
   // Stimulus and observation
   localparam logic [31:0] org_txt = 32'h4745_4E30; // Arbitrary origin text.
   typedef struct packed {src_t s; ref_t r; logic [2:0] e;} row_t;
   logic                 clk = 1'b0;
   logic                 rstn = 1'b0;
   logic                 ui_tick = 1'b0;
   logic                 ui_d = 1'b0;
   logic                 int_tick = 1'b0;
   logic [NLINK-1:0]     aes_tick = 4'h0;
   ref_t                 ref_sel = REF_INTERNAL;
   src_t                 src_sel = SRC_ANALOG;
   rate_t                rate_sel = RATE_32K;
   logic [NCH*SMP_W-1:0] src_v [5];
   logic [NLINK-1:0]     aes_out;
   logic                 block_start_q;
   rate_t                frame_rate_q;
   logic [NLINK-1:0]     rx_ok;
   pre_t                 rx_kind [NLINK];
   logic [27:0]          rx_bits [NLINK];
   logic [23:0]          a_w [NLINK];
   logic [23:0]          b_w [NLINK];
   logic [191:0]         cs_v;
   rate_t                blk_rate;
   int                   zc = 0;
   int                   idx = 0;
   int                   n_fail = 0;
   int                   checks_done = 0;
   int                   bs_n = 0;

   always #2 clk = ~clk;
   always @(posedge clk) ui_d <= ui_tick;
   always @(posedge clk) if (block_start_q) bs_n++;

   aes3_output_status_gen aes3_output_status_gen_inst (
      .clk               (clk),
      .rstn              (rstn),
      .ui_tick           (ui_tick),
      .int_frame_tick    (int_tick),
      .aes_in_frame_tick (aes_tick),
      .ref_sel           (ref_sel),
      .src_sel           (src_sel),
      .rate_sel          (rate_sel),
      .src_analog        (src_v[0]),
      .src_optical       (src_v[1]),
      .src_usb           (src_v[2]),
      .src_madi          (src_v[3]),
      .src_aes           (src_v[4]),
      .aes_out           (aes_out),
      .block_start_q     (block_start_q),
      .frame_rate_q      (frame_rate_q)
   );
   for (genvar k = 0; k < NLINK; k++) begin : g_rx
      bmc_rx_model bmc_rx_model_inst (
         .clk    (clk),
         .rstn   (rstn),
         .stb    (ui_d),
         .line   (aes_out[k]),
         .ok_q   (rx_ok[k]),
         .kind_q (rx_kind[k]),
         .bits   (rx_bits[k])
      );
   end

   function automatic logic [23:0] pat(int s, int c);
      return {s[3:0], c[3:0], 16'hA5C3};
   endfunction

   function automatic logic [191:0] exp_cs(rate_t r);
      logic [7:0]   b [24];
      logic [7:0]   crc;
      logic [191:0] v;
      b = '{default: 8'h00};
      crc = CRC_INIT;
      b[0] = CS_B0_PRO | CS_B0_NO_EMPH | (r == RATE_32K ? CS_B0_FS_32K :
             r == RATE_44K1 ? CS_B0_FS_44K1 : r == RATE_48K ? CS_B0_FS_48K : 8'h00);
      b[1] = CS_B1_TWO_CH;
      b[2] = CS_B2_AUX_AUD | CS_B2_WLEN_24;
      case (r)
         RATE_64K:   b[4] = CS_B4_64K;
         RATE_88K2:  b[4] = CS_B4_88K2;
         RATE_96K:   b[4] = CS_B4_96K;
         RATE_176K4: b[4] = CS_B4_176K4;
         RATE_192K:  b[4] = CS_B4_192K;
         default:    b[4] = 8'h00;
      endcase
      {b[6], b[7], b[8], b[9]} = org_txt;
      for (int i = 0; i < 184; i++) begin
         v[i] = b[i/8][i%8];
         crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ v[i]) ? CRC_POLY : 8'h00);
      end
      v[191:184] = crc;
      return v;
   endfunction

   task automatic chk(string n, logic [191:0] e, logic [191:0] s);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic close_out();
      if (n_fail == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic pulse_ref(logic [2:0] r);
      if (r >= 3'h1 && r <= 3'h4)
         aes_tick[r-3'h1] <= 1'b1;
      else
         int_tick <= 1'b1;
   endtask

   // A stray tick from an unselected reference lands mid-frame; honouring it would cut
   // the frame short and lose subframe B.
   // Fast frames tick every cycle so that seven whole status blocks fit in the run.
   task automatic frame(ref_t r, int nui, logic stray, logic fast);
      @(posedge clk);
      pulse_ref(r);
      @(posedge clk);
      int_tick <= 1'b0;
      aes_tick <= 4'h0;
      for (int k = 0; k < nui; k++) begin
         ui_tick <= 1'b1;
         if (stray && k == 80)
            pulse_ref((r >= REF_AES1 && r <= REF_AES4) ? 3'h0 : 3'h1);
         @(posedge clk);
         int_tick <= 1'b0;
         aes_tick <= 4'h0;
         if (!fast) begin
            ui_tick <= 1'b0;
            @(posedge clk);
         end
      end
      ui_tick <= 1'b0;
   endtask

   always @(posedge clk) begin
      for (int k = 0; k < NLINK; k++)
         if (rx_ok[k] && rx_kind[k] == PRE_Y)
            b_w[k] = rx_bits[k][23:0];
         else if (rx_ok[k])
            a_w[k] = rx_bits[k][23:0];
      if (rx_ok[0] && rx_kind[0] != PRE_Y) begin
         if (rx_kind[0] == PRE_Z) begin
            if (zc > 0) begin
               chk("block length", 191, idx);
               chk("status block", exp_cs(blk_rate), cs_v);
            end
            blk_rate = rate_sel;
            zc++;
            idx = 0;
         end else
            idx++;
         cs_v[idx] = rx_bits[0][26];
      end
   end

   // ==========
   // Sequence
   initial begin
      row_t  rows [6];
      rate_t rt [8];
      int    zs;
      rows = '{'{SRC_ANALOG, REF_INTERNAL, 3'h0}, '{SRC_OPTICAL, REF_AES1, 3'h1},
               '{SRC_USB, REF_AES2, 3'h2}, '{SRC_MADI, REF_AES3, 3'h3},
               '{SRC_AES, REF_AES4, 3'h4}, '{src_t'(3'h7), ref_t'(3'h6), 3'h0}};
      rt = '{RATE_32K, RATE_48K, RATE_64K, RATE_88K2, RATE_96K, RATE_176K4, RATE_192K,
             RATE_44K1};
      zs = 0;
      for (int s = 0; s < 5; s++)
         for (int c = 0; c < NCH; c++)
            src_v[s][24*c +: 24] = pat(s, c);
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         src_sel <= rows[i].s;
         ref_sel <= rows[i].r;
         a_w = '{default: 'x};
         b_w = '{default: 'x};
         frame(rows[i].r, 128, 1'b1, 1'b0);
         repeat (3) @(posedge clk);
         for (int k = 0; k < NLINK; k++) begin
            chk("subframe A", pat(rows[i].e, 2*k), a_w[k]);
            chk("subframe B", pat(rows[i].e, 2*k+1), b_w[k]);
         end
         chk("frame rate", RATE_32K, frame_rate_q);
      end
      ref_sel <= REF_INTERNAL;
      // The rate for a block is latched one frame ahead, so it is changed right after a start.
      for (int f = 0; f < 1400 && zc < 8; f++) begin
         if (zc != zs) begin
            zs = zc;
            rate_sel <= rt[zc];
         end
         frame(REF_INTERNAL, 64, 1'b0, 1'b1);
      end
      chk("block count", 8, zc);
      chk("block starts", zc, bs_n);
      frame(REF_INTERNAL, 20, 1'b0, 1'b0);
      rstn <= 1'b0;
      @(posedge clk);
      chk("line in reset", 4'h0, aes_out);
      chk("start in reset", 1'b0, block_start_q);
      chk("rate in reset", RATE_48K, frame_rate_q);
      rstn <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         ui_tick <= 1'b1;
         @(posedge clk);
         ui_tick <= 1'b0;
         @(posedge clk);
      end
      chk("idle line", 4'h0, aes_out);
      close_out();
   end
endmodule
